//--- hw/dadof_formatter.sv
`timescale 1ns/10ps
module dadof_formatter (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [dadof_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [dadof_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [dadof_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [dadof_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic encode_clock,
	input wire logic [dadof_pkg::SAMPLE_W-1:0] chan_a_code,
	input wire logic chan_a_above,
	input wire logic chan_a_below,
	input wire logic [dadof_pkg::SAMPLE_W-1:0] chan_b_code,
	input wire logic chan_b_above,
	input wire logic chan_b_below,
	input wire logic config_mode_select,
	input wire logic strap_cs,
	input wire logic strap_sdi,
	output logic [dadof_pkg::PAIRS-1:0] chan_a_pair_bits,
	output logic [dadof_pkg::PAIRS-1:0] chan_b_pair_bits,
	output logic range_violation_flag,
	output logic forwarded_output_clock,
	output logic [dadof_pkg::CUR_W-1:0] lvds_current_ua,
	output logic lvds_termination_en,
	output logic dcs_enabled,
	output logic irq
);
	import dadof_pkg::*;

	localparam int RAW_W = 2 * (SAMPLE_W + 2);
	localparam int WORD_W = 2 * (SAMPLE_W + 1);

	function automatic logic [SAMPLE_W:0] format_sample(input logic [SAMPLE_W-1:0] code,
		input logic above, input logic below, input logic twos);
		logic [SAMPLE_W-1:0] c;
		c = code;
		if (above)
			c = CODE_ONES;
		else if (below)
			c = CODE_ZERO;
		c[SAMPLE_W-1] = c[SAMPLE_W-1] ^ twos;
		return {above | below, c};
	endfunction

	function automatic logic [PAIRS-1:0] lane_bits(input logic [SAMPLE_W-1:0] w, input logic odd);
		logic [PAIRS-1:0] r;
		r = '0;
		for (int i = 0; i < PAIRS; i++)
			r[i] = odd ? w[2*i+1] : w[2*i];
		return r;
	endfunction

	function automatic logic [CUR_W-1:0] drive_ua(input logic [2:0] sel);
		logic [CUR_W-1:0] r;
		unique case (sel)
			3'h0: r = CUR_3500;
			3'h1: r = CUR_4000;
			3'h2: r = CUR_4500;
			3'h4: r = CUR_3000;
			3'h5: r = CUR_2500;
			3'h6: r = CUR_2100;
			3'h7: r = CUR_1750;
			default: r = CUR_3500;
		endcase
		return r;
	endfunction

	function automatic logic [7:0] mode_view(input logic [IDX_W-1:0] idx, input logic [7:0] c,
		input logic [7:0] d, input logic [7:0] f);
		logic [7:0] r;
		r = 8'h00;
		if (idx == IDX_CLOCK)
			r = c;
		else if (idx == IDX_DRIVE)
			r = d;
		else if (idx == IDX_FORMAT)
			r = f;
		return r;
	endfunction

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		return a == OFS_SERIAL || a == OFS_CLOCK || a == OFS_DRIVE || a == OFS_FORMAT
			|| a == OFS_IRQ_STATUS || a == OFS_IRQ_MASK || a == OFS_STATE;
	endfunction

	// Pin synchronisers; sample inputs are stable for a whole encode period
	logic enc_s1, enc_s2, enc_s3;
	logic [RAW_W-1:0] raw_s1, raw_s2;
	logic [2:0] strap_s1, strap_s2;
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			enc_s1 <= 1'b0;
			enc_s2 <= 1'b0;
			enc_s3 <= 1'b0;
			raw_s1 <= '0;
			raw_s2 <= '0;
			strap_s1 <= 3'h0;
			strap_s2 <= 3'h0;
		end
		else if (ce)
		begin
			enc_s1 <= encode_clock;
			enc_s2 <= enc_s1;
			enc_s3 <= enc_s2;
			raw_s1 <= {chan_a_above, chan_a_below, chan_a_code,
				chan_b_above, chan_b_below, chan_b_code};
			raw_s2 <= raw_s1;
			strap_s1 <= {config_mode_select, strap_cs, strap_sdi};
			strap_s2 <= strap_s1;
		end

	logic enc_rise, par_mode;
	assign enc_rise = enc_s2 & ~enc_s3;
	assign par_mode = strap_s2[2];

	// AXI4-Lite write channel: one write in flight, address and data in either order
	logic aw_got, w_got, wr_fire;
	logic [ADDR_W-1:0] aw_addr;
	logic [DATA_W-1:0] w_data;
	logic [3:0] w_strb;
	assign wr_fire = aw_got & w_got & ~s_axi_bvalid;
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			aw_got <= 1'b0;
			s_axi_awready <= 1'b0;
			aw_addr <= '0;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_addr <= s_axi_awaddr;
				aw_got <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			else if (wr_fire)
				aw_got <= 1'b0;
			else if (!aw_got && !s_axi_bvalid)
				s_axi_awready <= 1'b1;
		end
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			w_got <= 1'b0;
			s_axi_wready <= 1'b0;
			w_data <= '0;
			w_strb <= 4'h0;
		end
		else if (ce)
		begin
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				w_got <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			else if (wr_fire)
				w_got <= 1'b0;
			else if (!w_got && !s_axi_bvalid)
				s_axi_wready <= 1'b1;
		end
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= addr_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end

	// Mode register writes arrive directly or packed as a serial command word
	logic cfg_we;
	logic [IDX_W-1:0] cfg_idx;
	logic [7:0] cfg_data;
	always_comb
	begin
		cfg_we = 1'b0;
		cfg_idx = {1'b0, aw_addr[ADDR_W-1:2]};
		cfg_data = w_data[7:0];
		if (wr_fire && w_strb[0])
		begin
			if (aw_addr == OFS_SERIAL)
			begin
				cfg_we = w_strb[1] & ~w_data[SER_RW_BIT];
				cfg_idx = w_data[SER_ADDR_LSB +: IDX_W];
			end
			else
				// An unmapped byte address must not alias onto a mode register
				cfg_we = addr_mapped(aw_addr);
		end
	end

	logic [7:0] clock_ctrl_reg, output_drive_reg, data_format_reg, serial_rdata;
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			clock_ctrl_reg <= REG_RST;
			output_drive_reg <= REG_RST;
			data_format_reg <= REG_RST;
		end
		else if (ce && cfg_we)
		begin
			if (cfg_idx == IDX_RESET && cfg_data[SRST_BIT])
			begin
				// Self-clearing reset bit: it is never stored
				clock_ctrl_reg <= REG_RST;
				output_drive_reg <= REG_RST;
				data_format_reg <= REG_RST;
			end
			else if (cfg_idx == IDX_CLOCK)
				clock_ctrl_reg <= cfg_data;
			else if (cfg_idx == IDX_DRIVE)
				output_drive_reg <= cfg_data;
			else if (cfg_idx == IDX_FORMAT)
				data_format_reg <= cfg_data;
		end
	// Serial read command leaves register untouched and latches its value
	always_ff @(posedge aclk)
		if (!aresetn)
			serial_rdata <= REG_RST;
		else if (ce && wr_fire && aw_addr == OFS_SERIAL && w_strb[1:0] == 2'h3
			&& w_data[SER_RW_BIT])
			serial_rdata <= mode_view(w_data[SER_ADDR_LSB +: IDX_W], clock_ctrl_reg,
				output_drive_reg, data_format_reg);

	// Effective settings; parallel mode only honours the straps
	logic dcs_on, clk_invert, twos;
	logic [1:0] phase_sel;
	assign dcs_on = par_mode ? strap_s2[1] : clock_ctrl_reg[CLK_DCS_BIT];
	assign phase_sel = par_mode ? 2'h0 : clock_ctrl_reg[CLK_PHASE_LSB +: 2];
	assign clk_invert = ~par_mode & clock_ctrl_reg[CLK_INVERT_BIT];
	assign twos = ~par_mode & data_format_reg[FMT_TWOS_BIT];

	logic [CUR_W-1:0] base_ua;
	logic term_on;
	assign base_ua = par_mode ? (strap_s2[0] ? CUR_1750 : CUR_3500)
		: drive_ua(output_drive_reg[DRV_SEL_LSB +: 3]);
	assign term_on = ~par_mode & output_drive_reg[DRV_TERM_BIT];
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			lvds_current_ua <= CUR_3500;
			lvds_termination_en <= 1'b0;
			dcs_enabled <= 1'b0;
		end
		else if (ce)
		begin
			// Doubling keeps the swing with the extra internal load
			lvds_current_ua <= term_on ? {base_ua[CUR_W-2:0], 1'b0} : base_ua;
			lvds_termination_en <= term_on;
			dcs_enabled <= dcs_on;
		end

	// Encode period measurement drives the regenerated 50% clock
	logic [PERIOD_W-1:0] per_cnt, period;
	logic per_change;
	assign per_change = enc_rise && period != '0 && PERIOD_W'(per_cnt + 1'b1) != period;
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			per_cnt <= '0;
			period <= '0;
		end
		else if (ce)
		begin
			if (enc_rise)
			begin
				period <= PERIOD_W'(per_cnt + 1'b1);
				per_cnt <= '0;
			end
			else if (per_cnt != '1)
				per_cnt <= PERIOD_W'(per_cnt + 1'b1);
		end

	// Phase is resolved to an eighth of the measured period
	logic [PERIOD_W-1:0] off, pos;
	logic half, shifted;
	always_comb
	begin
		unique case (phase_sel)
			2'h0: off = '0;
			2'h1: off = period >> 3;
			2'h2: off = period >> 2;
			2'h3: off = PERIOD_W'((period >> 2) + (period >> 3));
		endcase
		pos = (per_cnt >= off) ? PERIOD_W'(per_cnt - off) : PERIOD_W'(per_cnt + period - off);
	end
	// Without the stabilizer the encode clock's own duty passes through
	assign half = dcs_on ? (per_cnt >= (period >> 1)) : enc_s2;
	// Shift only takes effect with the stabilizer running
	assign shifted = dcs_on ? (pos >= (period >> 1)) : enc_s2;

	// Sample pipeline: flag and code share every stage
	logic [WORD_W-1:0] pipe [PIPE_DEPTH];
	logic [WORD_W-1:0] word;
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			for (int i = 0; i < PIPE_DEPTH; i++)
				pipe[i] <= '0;
			word <= '0;
		end
		else if (ce && enc_rise)
		begin
			pipe[0] <= {format_sample(raw_s2[RAW_W-3 -: SAMPLE_W], raw_s2[RAW_W-1],
					raw_s2[RAW_W-2], twos),
				format_sample(raw_s2[SAMPLE_W-1:0], raw_s2[SAMPLE_W+1],
					raw_s2[SAMPLE_W], twos)};
			for (int i = 1; i < PIPE_DEPTH; i++)
				pipe[i] <= pipe[i-1];
			word <= pipe[PIPE_DEPTH-1];
		end

	logic flag_a, flag_b;
	logic [SAMPLE_W-1:0] word_a, word_b;
	assign {flag_a, word_a, flag_b, word_b} = word;

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			chan_a_pair_bits <= '0;
			chan_b_pair_bits <= '0;
			range_violation_flag <= 1'b0;
			forwarded_output_clock <= 1'b0;
		end
		else if (ce)
		begin
			chan_a_pair_bits <= lane_bits(word_a, half);
			chan_b_pair_bits <= lane_bits(word_b, half);
			range_violation_flag <= half ? flag_b : flag_a;
			forwarded_output_clock <= shifted ^ clk_invert;
		end

	// Interrupts: sticky, write one to clear, a new event beats the clear
	logic [IRQ_W-1:0] irq_status, irq_mask, irq_set, irq_clr;
	assign irq_set = (ce && enc_rise) ? {per_change, pipe[PIPE_DEPTH-1][SAMPLE_W],
		pipe[PIPE_DEPTH-1][WORD_W-1]} : '0;
	assign irq_clr = (wr_fire && aw_addr == OFS_IRQ_STATUS && w_strb[0]) ? w_data[IRQ_W-1:0] : '0;
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			irq_status <= '0;
			irq_mask <= '0;
			irq <= 1'b0;
		end
		else if (ce)
		begin
			irq_status <= (irq_status & ~irq_clr) | irq_set;
			if (wr_fire && aw_addr == OFS_IRQ_MASK && w_strb[0])
				irq_mask <= w_data[IRQ_W-1:0];
			irq <= |(irq_status & irq_mask);
		end

	// AXI4-Lite read channel
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
				if (s_axi_araddr == OFS_SERIAL)
					s_axi_rdata <= {24'h000000, serial_rdata};
				else if (s_axi_araddr == OFS_IRQ_STATUS)
					s_axi_rdata <= {29'h00000000, irq_status};
				else if (s_axi_araddr == OFS_IRQ_MASK)
					s_axi_rdata <= {29'h00000000, irq_mask};
				else if (s_axi_araddr == OFS_STATE)
					s_axi_rdata <= {22'h000000, period, dcs_on, par_mode};
				else
					s_axi_rdata <= {24'h000000, mode_view({1'b0, s_axi_araddr[ADDR_W-1:2]},
						clock_ctrl_reg, output_drive_reg, data_format_reg)};
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			else if (!s_axi_rvalid)
				s_axi_arready <= 1'b1;
		end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_sample_above_a;
		ce && enc_rise && raw_s2[RAW_W-1];
	endsequence
	sequence s_mid_a;
		ce && enc_rise && !raw_s2[RAW_W-1] && !raw_s2[RAW_W-2]
			&& raw_s2[RAW_W-3 -: SAMPLE_W] == CODE_MID;
	endsequence
	sequence s_drive_term_write;
		ce && !par_mode && cfg_we && cfg_idx == IDX_DRIVE && cfg_data[3:0] == 4'h8;
	endsequence
	sequence s_serial_fmt_write;
		ce && wr_fire && aw_addr == OFS_SERIAL && w_strb[1:0] == 2'h3
			&& !w_data[SER_RW_BIT] && w_data[SER_ADDR_LSB +: IDX_W] == IDX_FORMAT;
	endsequence

	a_pipe_latency: assert property (ce && enc_rise |=> word == $past(pipe[PIPE_DEPTH-1]))
		else $error("output word did not take the last pipeline stage");
	a_lane_even: assert property (ce && !half |=> chan_a_pair_bits == lane_bits($past(word_a), 1'b0))
		else $error("even bits not presented in low half");
	a_flag_by_level: assert property (ce |=> range_violation_flag
		== ($past(half) ? $past(flag_b) : $past(flag_a)))
		else $error("range flag not multiplexed by clock level");
	a_sat_above: assert property (s_sample_above_a |=> pipe[0][WORD_W-1]
		&& pipe[0][WORD_W-2 -: SAMPLE_W] == ($past(twos) ? 14'h1FFF : CODE_ONES))
		else $error("above-range sample not saturated with flag");
	a_mid_code: assert property (s_mid_a |=> pipe[0][WORD_W-2 -: SAMPLE_W]
		== ($past(twos) ? CODE_ZERO : CODE_MID))
		else $error("mid-scale code wrong");
	a_term_double: assert property (s_drive_term_write ##1 (ce && !par_mode)
		|=> lvds_current_ua == CUR_7000)
		else $error("termination did not double 3.5mA");
	a_clock_invert: assert property (ce && dcs_on && phase_sel == 2'h0
		|=> forwarded_output_clock == ($past(half) ^ $past(clk_invert)))
		else $error("forwarded clock polarity wrong");
	a_dcs_strap: assert property (ce && par_mode |=> dcs_enabled == $past(strap_s2[1]))
		else $error("stabilizer enable does not follow strap");
	a_serial_write: assert property (s_serial_fmt_write |=> data_format_reg == $past(w_data[7:0]))
		else $error("serial command did not write format register");
	a_irq_set_wins: assert property (irq_set[IRQ_A_BIT] && irq_clr[IRQ_A_BIT] |=> irq_status[IRQ_A_BIT])
		else $error("clear beat a simultaneous event");
endmodule

//--- hw/dadof_pkg.sv
package dadof_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int SAMPLE_W = 14;
	localparam int PAIRS = 7;
	localparam int PIPE_DEPTH = 5;
	localparam int PERIOD_W = 8;
	localparam int CUR_W = 14;
	localparam int IDX_W = 7;
	localparam int IRQ_W = 3;
	// Register byte offsets; mode registers sit at four times their index
	localparam logic [ADDR_W-1:0] OFS_SERIAL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CLOCK = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_DRIVE = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_FORMAT = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_STATE = 8'h1C;
	localparam logic [IDX_W-1:0] IDX_RESET = 7'h00;
	localparam logic [IDX_W-1:0] IDX_CLOCK = 7'h02;
	localparam logic [IDX_W-1:0] IDX_DRIVE = 7'h03;
	localparam logic [IDX_W-1:0] IDX_FORMAT = 7'h04;
	localparam logic [7:0] REG_RST = 8'h00;
	// Field positions
	localparam int SRST_BIT = 7;
	localparam int CLK_DCS_BIT = 0;
	localparam int CLK_PHASE_LSB = 1;
	localparam int CLK_INVERT_BIT = 3;
	localparam int DRV_SEL_LSB = 0;
	localparam int DRV_TERM_BIT = 3;
	localparam int FMT_TWOS_BIT = 0;
	localparam int SER_RW_BIT = 15;
	localparam int SER_ADDR_LSB = 8;
	localparam int IRQ_A_BIT = 0;
	localparam int IRQ_B_BIT = 1;
	localparam int IRQ_PERIOD_BIT = 2;
	// Sample codes
	localparam logic [SAMPLE_W-1:0] CODE_MID = 14'h2000;
	localparam logic [SAMPLE_W-1:0] CODE_ONES = 14'h3FFF;
	localparam logic [SAMPLE_W-1:0] CODE_ZERO = 14'h0000;
	// Driver currents in microamps
	localparam logic [CUR_W-1:0] CUR_1750 = 14'h06D6;
	localparam logic [CUR_W-1:0] CUR_2100 = 14'h0834;
	localparam logic [CUR_W-1:0] CUR_2500 = 14'h09C4;
	localparam logic [CUR_W-1:0] CUR_3000 = 14'h0BB8;
	localparam logic [CUR_W-1:0] CUR_3500 = 14'h0DAC;
	localparam logic [CUR_W-1:0] CUR_4000 = 14'h0FA0;
	localparam logic [CUR_W-1:0] CUR_4500 = 14'h1194;
	localparam logic [CUR_W-1:0] CUR_7000 = 14'h1B58;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- testbench/dadof_receiver.sv
`timescale 1ns/10ps
module dadof_receiver (
	input wire logic aclk,
	input wire logic [dadof_pkg::PAIRS-1:0] lane_a,
	input wire logic [dadof_pkg::PAIRS-1:0] lane_b,
	input wire logic flag,
	input wire logic fclk,
	output logic [dadof_pkg::SAMPLE_W-1:0] word_a,
	output logic [dadof_pkg::SAMPLE_W-1:0] word_b,
	output logic flag_a,
	output logic flag_b
);
	import dadof_pkg::*;
	logic [PAIRS-1:0] ea, eb, oa, ob;
	logic fa, fb, prev;
	initial
	begin
		prev = 1'b0;
		word_a = '0;
		word_b = '0;
		flag_a = 1'b0;
		flag_b = 1'b0;
	end
	// Sampled mid-cycle, the way a source-synchronous capture centres on the eye
	always @(negedge aclk)
	begin
		if (prev && !fclk)
		begin
			for (int i = 0; i < PAIRS; i++)
			begin
				word_a[2*i] = ea[i];
				word_a[2*i+1] = oa[i];
				word_b[2*i] = eb[i];
				word_b[2*i+1] = ob[i];
			end
			flag_a = fa;
			flag_b = fb;
		end
		if (!fclk)
		begin
			ea = lane_a;
			eb = lane_b;
			fa = flag;
		end
		else
		begin
			oa = lane_a;
			ob = lane_b;
			fb = flag;
		end
		prev = fclk;
	end
endmodule

//--- testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
	import dadof_pkg::*;
	localparam int P = 16;
	logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic encode_clock, chan_a_above, chan_a_below, chan_b_above, chan_b_below;
	logic config_mode_select, strap_cs, strap_sdi, range_violation_flag, forwarded_output_clock;
	logic lvds_termination_en, dcs_enabled, irq, rx_fa, rx_fb;
	logic [SAMPLE_W-1:0] chan_a_code, chan_b_code, rx_a, rx_b;
	logic [PAIRS-1:0] chan_a_pair_bits, chan_b_pair_bits;
	logic [CUR_W-1:0] lvds_current_ua;
	int bad_count, checked, n;

	dadof_formatter u_dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .encode_clock, .chan_a_code, .chan_a_above, .chan_a_below,
		.chan_b_code, .chan_b_above, .chan_b_below, .config_mode_select, .strap_cs, .strap_sdi,
		.chan_a_pair_bits, .chan_b_pair_bits, .range_violation_flag, .forwarded_output_clock,
		.lvds_current_ua, .lvds_termination_en, .dcs_enabled, .irq);
	dadof_receiver u_rx (.aclk, .lane_a(chan_a_pair_bits), .lane_b(chan_b_pair_bits),
		.flag(range_violation_flag), .fclk(forwarded_output_clock), .word_a(rx_a),
		.word_b(rx_b), .flag_a(rx_fa), .flag_b(rx_fb));

	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// Offset start keeps the encode edges off the aclk edges
	initial
	begin
		encode_clock = 1'b0;
		#5;
		forever #32 encode_clock = ~encode_clock;
	end

	task chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask

	task conclude;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		logic ad, dd;
		ad = 1'b0;
		dd = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(ad && dd))
		begin
			@(posedge aclk);
			if (!ad && s_axi_awready === 1'b1)
			begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!dd && s_axi_wready === 1'b1)
			begin
				dd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	function automatic logic [SAMPLE_W-1:0] ex(input logic [SAMPLE_W-1:0] c, input logic up,
		input logic dn, input logic tw);
		logic [SAMPLE_W-1:0] v;
		v = up ? CODE_ONES : (dn ? CODE_ZERO : c);
		v[SAMPLE_W-1] = v[SAMPLE_W-1] ^ tw;
		return v;
	endfunction

	function automatic logic [CUR_W-1:0] ex_cur(input logic [3:0] s);
		logic [CUR_W-1:0] t [8];
		t = '{CUR_3500, CUR_4000, CUR_4500, CUR_3500, CUR_3000, CUR_2500, CUR_2100, CUR_1750};
		return s[3] ? t[s[2:0]] << 1 : t[s[2:0]];
	endfunction

	// Held for eight encode periods so the five-deep pipeline has fully refilled
	task automatic sample(input logic [SAMPLE_W-1:0] ca, input logic [SAMPLE_W-1:0] cb,
		input logic [3:0] o, input logic tw);
		@(posedge aclk);
		chan_a_code <= ca;
		chan_b_code <= cb;
		{chan_a_above, chan_a_below, chan_b_above, chan_b_below} <= o;
		repeat (8 * P) @(posedge aclk);
		@(negedge aclk);
		chk(rx_a === ex(ca, o[3], o[2], tw) && rx_fa === (o[3] | o[2]), "lane a");
		chk(rx_b === ex(cb, o[1], o[0], tw) && rx_fb === (o[1] | o[0]), "lane b");
	endtask

	// Clock rise measured from the flag's A-to-B change, which marks the unshifted half
	task automatic meas(output int c);
		logic pf, pc, go;
		pf = 1'b0;
		pc = 1'b1;
		go = 1'b0;
		while (!go)
		begin
			@(negedge aclk);
			go = pf && !range_violation_flag;
			pf = range_violation_flag;
			if (!go)
				pc = forwarded_output_clock;
		end
		c = 0;
		while (!(forwarded_output_clock && !pc) && c < 40)
		begin
			pc = forwarded_output_clock;
			@(negedge aclk);
			c++;
		end
	endtask

	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{chan_a_code, chan_b_code, chan_a_above, chan_a_below, chan_b_above, chan_b_below} = '0;
		{config_mode_select, strap_cs, strap_sdi} = '0;
		ce = 1'b1;
		void'($urandom(32'hec70));
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		chk(lvds_current_ua === CUR_3500 && dcs_enabled === 1'b0, "reset drive");
		rd(OFS_CLOCK);
		chk(d === 32'h0 && r === RESP_OKAY, "reset clock reg");
		rd(8'h40);
		chk(r === RESP_SLVERR, "unmapped read");
		for (int f = 0; f < 2; f++)
		begin
			wr(OFS_FORMAT, DATA_W'(f));
			sample(CODE_MID, CODE_MID, 4'b0000, f[0]);
			sample(14'($urandom), 14'($urandom), 4'b1001, f[0]);
			sample(14'($urandom), 14'($urandom), 4'b0110, f[0]);
			repeat (4) sample(14'($urandom), 14'($urandom), 4'b0000, f[0]);
		end
		wr(OFS_FORMAT, 32'h0);
		for (int s = 0; s < 16; s++)
		begin
			wr(OFS_DRIVE, DATA_W'(s));
			repeat (4) @(posedge aclk);
			chk(lvds_current_ua === ex_cur(4'(s)) && lvds_termination_en === s[3], "drive");
		end
		wr(OFS_SERIAL, {16'h0, 1'b0, IDX_DRIVE, 8'h07});
		repeat (4) @(posedge aclk);
		chk(r === RESP_OKAY && lvds_current_ua === CUR_1750, "serial write");
		wr(OFS_SERIAL, {16'h0, 1'b1, IDX_DRIVE, 8'h00});
		rd(OFS_SERIAL);
		chk(d === 32'h07 && lvds_current_ua === CUR_1750, "serial readback");
		wr(OFS_SERIAL, {16'h0, 1'b0, IDX_FORMAT, 8'h01});
		sample(CODE_MID, 14'($urandom), 4'b0000, 1'b1);
		wr(OFS_SERIAL, {16'h0, 1'b0, IDX_RESET, 8'h80});
		repeat (4) @(posedge aclk);
		chk(lvds_current_ua === CUR_3500, "soft reset");
		{chan_a_above, chan_a_below, chan_b_above, chan_b_below} <= 4'b1000;
		for (int k = 0; k < 8; k++)
		begin
			wr(OFS_CLOCK, DATA_W'(k * 2 + 1));
			repeat (4 * P) @(posedge aclk);
			meas(n);
			chk(n == (k % 4) * (P / 8) + (k / 4) * (P / 2) && dcs_enabled === 1'b1, "phase");
		end
		wr(OFS_IRQ_STATUS, 32'h7);
		wr(OFS_IRQ_MASK, 32'h1);
		repeat (4) @(posedge aclk);
		chk(irq === 1'b1, "irq raised");
		wr(OFS_IRQ_MASK, 32'h0);
		repeat (4) @(posedge aclk);
		chk(irq === 1'b0, "irq masked");
		chan_a_above <= 1'b0;
		repeat (8 * P) @(posedge aclk);
		wr(OFS_IRQ_STATUS, 32'h7);
		rd(OFS_IRQ_STATUS);
		chk(d[IRQ_A_BIT] === 1'b0, "status cleared");
		wr(OFS_IRQ_MASK, 32'h1);
		repeat (4) @(posedge aclk);
		chk(irq === 1'b0, "irq cleared");
		config_mode_select <= 1'b1;
		strap_cs <= 1'b1;
		strap_sdi <= 1'b1;
		repeat (8) @(posedge aclk);
		chk(lvds_current_ua === CUR_1750 && dcs_enabled === 1'b1, "strap on");
		strap_cs <= 1'b0;
		strap_sdi <= 1'b0;
		repeat (8) @(posedge aclk);
		chk(lvds_current_ua === CUR_3500 && dcs_enabled === 1'b0, "strap off");
		conclude;
	end

	initial
	begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		$display("CHECK FAILED at %0t: timeout", $time);
		conclude;
	end
endmodule
